// *** design/amee_consts.svh ***
// Purpose: constants of the motion event engines
// Assumes: samples carry 1024 LSB per g in the 2g range
// Notes: register byte address is the index times four
`ifndef AMEE_CONSTS_SVH
`define AMEE_CONSTS_SVH
// register indices
`define AMEE_IX_INTST 8'h09
`define AMEE_IX_POS 8'h0C
`define AMEE_IX_ENA 8'h16
`define AMEE_IX_ENB 8'h17
`define AMEE_IX_LODUR 8'h22
`define AMEE_IX_LOTH 8'h23
`define AMEE_IX_HYMD 8'h24
`define AMEE_IX_HIDUR 8'h25
`define AMEE_IX_HITH 8'h26
`define AMEE_IX_ORMD 8'h2C
`define AMEE_IX_ORANG 8'h2D
`define AMEE_IX_FLANG 8'h2E
`define AMEE_IX_FLHLD 8'h2F
`define AMEE_IX_CTRL 8'h30
`define AMEE_RST_CFG 8'h00
// field positions
`define AMEE_ST_LOW 0
`define AMEE_ST_HIGH 1
`define AMEE_ST_ORI 6
`define AMEE_ST_FLAT 7
`define AMEE_EN_ORI 6
`define AMEE_EN_FLAT 7
`define AMEE_EN_LOW 3
`define AMEE_LOW_MODE 2
`define AMEE_UD_EN 6
`define AMEE_CTRL_LATCH 2
`define AMEE_CTRL_IRST 7
// accelerations in 2g-range sample LSB
`define AMEE_G1P5 16'h0600
`define AMEE_G0P2 16'h00CD
`define AMEE_G0P4 16'h019A
`define AMEE_TAN_SHIFT 16
// times in ms and the microsecond counter ceiling
`define AMEE_US_PER_MS 1000
`define AMEE_DUR_STEP_MS 2
`define AMEE_ORI_STABLE_MS 100
`define AMEE_HOLD1_MS 512
`define AMEE_HOLD2_MS 1024
`define AMEE_HOLD3_MS 2048
`define AMEE_US_CAP 22'h200B20
`endif

// *** design/amee_pkg.sv ***
// Purpose: types of the motion event engines
// Assumes: APB with 12-bit byte address
// Notes: structs carry bus and sample groups
package amee_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } amee_apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } amee_apb_rsp_type;
  typedef struct packed {
    logic valid;
    logic signed [11:0] x;
    logic signed [11:0] y;
    logic signed [11:0] z;
    logic [1:0] orient_xy;
  } amee_sample_type;
  typedef enum logic [1:0] {
    AMEE_BLK_NONE = 2'b00,
    AMEE_BLK_TILT = 2'b01,
    AMEE_BLK_SLOW = 2'b10,
    AMEE_BLK_FULL = 2'b11
  } amee_block_type;
endpackage

// *** design/amee_engines.sv ***
// Purpose: orientation blocking, flat, low-g and high-g event engines
// Assumes: samples are 12-bit two's complement, 1024 LSB/g at 2g range
// Notes: APB slave, zero wait states while ce is high
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "amee_consts.svh"

// Function
// - blocking code 00 off, 01 tilt or 1.5g
// - code 10 adds slope above 0.2g
// - code 11: slope 0.4g, unstable 100 ms
// - tilt blocks when tangent below root(field)/8
// - z sign flips only past 0.2g
// - up-down enable decides z-bit events
// - flat angle is atan of root(field)/8
// - flat hysteresis gives enter and leave thresholds
// - flat bit shows position while enabled
// - flat event after new value holds
// - unlatched flat status lasts one sample
// - low-g set below threshold, single or sum
// - low-g threshold 7.81 mg per step
// - low-g hysteresis 125 mg per step
// - low-g resets above threshold plus hysteresis
// - low-g delay is (field+1) times 2 ms
// - high-g set when enabled axis exceeds
// - high-g threshold step scales with range
// - high-g hysteresis step scales with range
// - high-g resets below threshold minus hysteresis
// - high-g delay is (field+1) times 2 ms
// - high-g records first axis and sign
// - orientation change raises orientation event
// - orientation top bit is z sign
module amee_engines
  import amee_pkg::*;
#(
  parameter int SAMPLE_PERIOD_US = 2000 // time between filtered samples
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce, // freezes all state while low
  input wire amee_apb_req_type apb_req,
  output var amee_apb_rsp_type apb_rsp,
  input wire amee_sample_type smp, // filtered sample, same clock
  output var logic [7:0] int_status, // event status register
  output var logic [7:0] pos_status // position and shock register
);

  // refuse periods the counters cannot serve
  if (SAMPLE_PERIOD_US < 1 || SAMPLE_PERIOD_US > 100000) begin : g_bad_period
    $error("sample period out of range");
  end

  localparam logic [21:0] PER = 22'(SAMPLE_PERIOD_US);
  localparam logic [21:0] STEP_US = 22'(`AMEE_DUR_STEP_MS * `AMEE_US_PER_MS);
  localparam logic [21:0] STABLE_US = 22'(`AMEE_ORI_STABLE_MS * `AMEE_US_PER_MS);

  // magnitude of a difference of two samples
  function automatic logic [15:0] amee_absdiff(input logic signed [11:0] a,
                                               input logic signed [11:0] b);
    logic signed [12:0] d;
    d = 13'(a) - 13'(b);
    return d[12] ? 16'(-d) : 16'(d);
  endfunction

  // tangent test: 65536*(x2+y2) < coef*z2, coef in 1/1024
  function automatic logic amee_tilt_below(input logic [15:0] ax, input logic [15:0] ay,
                                           input logic [15:0] az, input logic [16:0] coef);
    logic [47:0] l;
    logic [47:0] r;
    l = (48'(ax) * 48'(ax) + 48'(ay) * 48'(ay)) << `AMEE_TAN_SHIFT;
    r = 48'(coef) * 48'(az) * 48'(az);
    return l < r;
  endfunction

  // saturating microsecond accumulator
  function automatic logic [21:0] amee_acc(input logic [21:0] c);
    return (c >= `AMEE_US_CAP) ? c : c + PER;
  endfunction

  // qualification delay from a duration field
  function automatic logic [21:0] amee_dur(input logic [7:0] f);
    return (22'(f) + 22'h000001) * STEP_US;
  endfunction

  // configuration registers
  logic [7:0] en_a_reg;
  logic [7:0] en_b_reg;
  logic [7:0] lo_dur_reg;
  logic [7:0] lo_th_reg;
  logic [7:0] hy_md_reg;
  logic [7:0] hi_dur_reg;
  logic [7:0] hi_th_reg;
  logic [7:0] or_md_reg;
  logic [7:0] or_ang_reg;
  logic [7:0] fl_ang_reg;
  logic [7:0] fl_hld_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] stat_reg; // event status
  logic [31:0] rdata_reg; // read data
  // engine state
  logic signed [11:0] px_reg;
  logic signed [11:0] py_reg;
  logic signed [11:0] pz_reg;
  logic zdir_reg;
  logic [2:0] cand_reg; // last candidate orientation
  logic [21:0] stab_us_reg;
  logic [2:0] orient_reg;
  logic flat_reg;
  logic fl_pend_reg;
  logic [21:0] fl_us_reg;
  logic lo_act_reg;
  logic [21:0] lo_us_reg;
  logic hi_act_reg;
  logic [21:0] hi_us_reg;
  logic [2:0] first_reg;
  logic sign_reg;

  // bus decode
  wire [7:0] idx = apb_req.paddr[9:2];
  wire aligned = apb_req.paddr[1:0] == 2'b00 && apb_req.paddr[11:10] == 2'b00;
  wire setup = ce && apb_req.psel && !apb_req.penable;
  wire access = ce && apb_req.psel && apb_req.penable;
  logic mapped;
  logic [7:0] rd_val;
  wire wr = access && apb_req.pwrite && mapped;
  wire irst = wr && idx == `AMEE_IX_CTRL && apb_req.pwdata[`AMEE_CTRL_IRST];
  wire latch = ctrl_reg[`AMEE_CTRL_LATCH];
  wire [1:0] rng = ctrl_reg[1:0];
  wire flat_en = en_a_reg[`AMEE_EN_FLAT];

  // read mux and address map
  always_comb begin
    mapped = aligned;
    case (idx)
      `AMEE_IX_INTST: rd_val = stat_reg;
      `AMEE_IX_POS: rd_val = pos_status;
      `AMEE_IX_ENA: rd_val = en_a_reg;
      `AMEE_IX_ENB: rd_val = en_b_reg;
      `AMEE_IX_LODUR: rd_val = lo_dur_reg;
      `AMEE_IX_LOTH: rd_val = lo_th_reg;
      `AMEE_IX_HYMD: rd_val = hy_md_reg;
      `AMEE_IX_HIDUR: rd_val = hi_dur_reg;
      `AMEE_IX_HITH: rd_val = hi_th_reg;
      `AMEE_IX_ORMD: rd_val = or_md_reg;
      `AMEE_IX_ORANG: rd_val = or_ang_reg;
      `AMEE_IX_FLANG: rd_val = fl_ang_reg;
      `AMEE_IX_FLHLD: rd_val = fl_hld_reg;
      `AMEE_IX_CTRL: rd_val = ctrl_reg;
      default: begin
        rd_val = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  assign apb_rsp = '{pready: ce, pslverr: access && !mapped, prdata: rdata_reg};

  // register writes; read data latched in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_a_reg <= `AMEE_RST_CFG;
      en_b_reg <= `AMEE_RST_CFG;
      lo_dur_reg <= `AMEE_RST_CFG;
      lo_th_reg <= `AMEE_RST_CFG;
      hy_md_reg <= `AMEE_RST_CFG;
      hi_dur_reg <= `AMEE_RST_CFG;
      hi_th_reg <= `AMEE_RST_CFG;
      or_md_reg <= `AMEE_RST_CFG;
      or_ang_reg <= `AMEE_RST_CFG;
      fl_ang_reg <= `AMEE_RST_CFG;
      fl_hld_reg <= `AMEE_RST_CFG;
      ctrl_reg <= `AMEE_RST_CFG;
      rdata_reg <= 32'h00000000;
    end else begin
      if (setup) begin
        rdata_reg <= {24'h000000, rd_val};
      end
      if (wr) begin
        case (idx)
          `AMEE_IX_ENA: en_a_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_ENB: en_b_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_LODUR: lo_dur_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_LOTH: lo_th_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_HYMD: hy_md_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_HIDUR: hi_dur_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_HITH: hi_th_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_ORMD: or_md_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_ORANG: or_ang_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_FLANG: fl_ang_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_FLHLD: fl_hld_reg <= apb_req.pwdata[7:0];
          `AMEE_IX_CTRL: ctrl_reg <= {1'b0, apb_req.pwdata[6:0]};
          default: ;
        endcase
      end
    end
  end

  wire go = ce && smp.valid;
  wire [15:0] mx = amee_absdiff(smp.x, 12'sh000);
  wire [15:0] my = amee_absdiff(smp.y, 12'sh000);
  wire [15:0] mz = amee_absdiff(smp.z, 12'sh000);
  wire [15:0] sx = amee_absdiff(smp.x, px_reg);
  wire [15:0] sy = amee_absdiff(smp.y, py_reg);
  wire [15:0] sz = amee_absdiff(smp.z, pz_reg);
  wire [15:0] g15 = `AMEE_G1P5 >> rng;
  wire [15:0] g02 = `AMEE_G0P2 >> rng;
  wire [15:0] g04 = `AMEE_G0P4 >> rng;
  wire over_15 = mx > g15 || my > g15 || mz > g15;
  wire slope_02 = sx > g02 || sy > g02 || sz > g02;
  wire slope_04 = sx > g04 || sy > g04 || sz > g04;
  wire tilt_blk = amee_tilt_below(mx, my, mz, {1'b0, or_ang_reg[5:0], 10'h000});

  // top bit set for negative z
  wire zdir_nx = (mz > g02) ? smp.z[11] : zdir_reg;
  wire [2:0] cand = {zdir_nx, smp.orient_xy};
  wire [21:0] stab_nx = (cand != cand_reg) ? 22'h000000 : amee_acc(stab_us_reg);
  wire unstable = stab_nx < STABLE_US;

  // blocking selector
  amee_block_type blk_mode;
  logic blocked;
  assign blk_mode = amee_block_type'(or_md_reg[3:2]);
  always_comb begin
    case (blk_mode)
      AMEE_BLK_NONE: blocked = 1'b0;
      AMEE_BLK_TILT: blocked = tilt_blk || over_15;
      AMEE_BLK_SLOW: blocked = tilt_blk || over_15 || slope_02;
      AMEE_BLK_FULL: blocked = tilt_blk || over_15 || slope_04 || unstable;
      default: blocked = 1'b0;
    endcase
  end

  // z bit counts only when enabled
  wire ori_chg = or_ang_reg[`AMEE_UD_EN] ? (cand != orient_reg)
                                         : (cand[1:0] != orient_reg[1:0]);
  wire ori_fire = !blocked && ori_chg && en_a_reg[`AMEE_EN_ORI];

  wire [2:0] fhy = fl_hld_reg[2:0];
  wire [16:0] f_base = {1'b0, fl_ang_reg[5:0], 10'h000};
  wire [16:0] f_adj = 17'(fl_ang_reg[5:0]) * 17'(fhy) + {8'h00, fhy, 6'h00};
  wire [16:0] c_ll = (f_base > f_adj) ? f_base - f_adj : 17'h00000;
  wire [16:0] c_ul = f_base + f_adj;
  wire flat_nx = amee_tilt_below(mx, my, mz, flat_reg ? c_ul : c_ll);

  wire [1:0] hcode = fl_hld_reg[5:4];
  wire [21:0] hold_us = (hcode == 2'b00) ? 22'h000000 :
                        (hcode == 2'b01) ? 22'(`AMEE_HOLD1_MS * `AMEE_US_PER_MS) :
                        (hcode == 2'b10) ? 22'(`AMEE_HOLD2_MS * `AMEE_US_PER_MS) :
                        22'(`AMEE_HOLD3_MS * `AMEE_US_PER_MS);
  wire fl_chg = flat_nx != flat_reg;
  wire fl_pend = fl_chg || fl_pend_reg;
  wire [21:0] fl_el = fl_chg ? 22'h000000 : amee_acc(fl_us_reg);
  wire fl_done = fl_pend && fl_el >= hold_us;
  wire fl_fire = fl_done && flat_en;

  // threshold 8 LSB per step, range scaled
  wire [15:0] lthr = {5'h00, lo_th_reg, 3'h0} >> rng;
  wire [15:0] lhy = {7'h00, hy_md_reg[1:0], 7'h00} >> rng;
  wire [15:0] lup = lthr + lhy;
  wire [15:0] lsum = mx + my + mz;
  wire lmode = hy_md_reg[`AMEE_LOW_MODE];
  wire lo_below = lmode ? lsum < lthr : (mx < lthr && my < lthr && mz < lthr);
  wire lo_above = lmode ? lsum > lup : (mx > lup || my > lup || mz > lup);
  wire [21:0] lo_el = lo_below ? amee_acc(lo_us_reg) : 22'h000000;
  wire lo_set = !lo_act_reg && lo_below && lo_el >= amee_dur(lo_dur_reg);
  wire lo_clr = lo_act_reg && lo_above;
  wire lo_act_nx = (lo_act_reg || lo_set) && !lo_clr && en_b_reg[`AMEE_EN_LOW];

  // step equals 8 LSB of the current range
  wire [15:0] hthr = {5'h00, hi_th_reg, 3'h0};
  wire [15:0] hhy = {7'h00, hy_md_reg[7:6], 7'h00};
  wire [15:0] hlo = (hthr > hhy) ? hthr - hhy : 16'h0000;
  wire [2:0] hen = en_b_reg[2:0];
  wire [2:0] hov = hen & {mz > hthr, my > hthr, mx > hthr};
  // all enabled axes under lower level
  wire hi_under = !(|(hen & {mz >= hlo, my >= hlo, mx >= hlo}));
  wire hi_cond = hi_act_reg ? hi_under : |hov;
  wire [21:0] hi_el = hi_cond ? amee_acc(hi_us_reg) : 22'h000000;
  wire hi_flip = hi_cond && hi_el >= amee_dur(hi_dur_reg);
  wire hi_act_nx = (hi_act_reg ^ hi_flip) && |hen;
  wire hi_rise = go && !hi_act_reg && hi_act_nx;

  // engine state advance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      px_reg <= 12'sh000;
      py_reg <= 12'sh000;
      pz_reg <= 12'sh000;
      zdir_reg <= 1'b0;
      cand_reg <= 3'b000;
      stab_us_reg <= 22'h000000;
      orient_reg <= 3'b000;
      flat_reg <= 1'b0;
      fl_pend_reg <= 1'b0;
      fl_us_reg <= 22'h000000;
      lo_act_reg <= 1'b0;
      lo_us_reg <= 22'h000000;
      hi_act_reg <= 1'b0;
      hi_us_reg <= 22'h000000;
    end else if (go) begin
      px_reg <= smp.x;
      py_reg <= smp.y;
      pz_reg <= smp.z;
      zdir_reg <= zdir_nx;
      cand_reg <= cand;
      stab_us_reg <= stab_nx;
      // blocked values never reach the result
      if (!blocked) begin
        orient_reg <= cand;
      end
      flat_reg <= flat_nx;
      fl_pend_reg <= fl_pend && !fl_done;
      fl_us_reg <= fl_el;
      lo_act_reg <= lo_act_nx;
      lo_us_reg <= lo_act_nx ? 22'h000000 : lo_el;
      hi_act_reg <= hi_act_nx;
      hi_us_reg <= hi_flip ? 22'h000000 : hi_el;
    end
  end

  // status: unlatched follows sample, latched sticky, set beats clear
  wire [7:0] raw = {fl_fire, ori_fire, 4'h0, hi_act_nx, lo_act_nx};
  wire [7:0] stat_nx = (go && !latch) ? raw :
                       ((stat_reg & ~{8{irst && latch}}) | (go ? raw : 8'h00));
  // first axis and sign on rise
  wire [2:0] first_new = hov[0] ? 3'b001 : hov[1] ? 3'b010 : 3'b100;
  wire sign_new = hov[0] ? smp.x[11] : hov[1] ? smp.y[11] : smp.z[11];

  // status, first axis and sign
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 8'h00;
      first_reg <= 3'b000;
      sign_reg <= 1'b0;
    end else if (ce) begin
      stat_reg <= stat_nx;
      if (hi_rise) begin
        first_reg <= first_new;
        sign_reg <= sign_new;
      end else if (!stat_nx[`AMEE_ST_HIGH]) begin
        first_reg <= 3'b000;
      end
    end
  end

  assign pos_status = {flat_en && flat_reg, orient_reg, sign_reg, first_reg};
  assign int_status = stat_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_blk_none;
    go && blk_mode == AMEE_BLK_NONE |=> orient_reg == $past(cand);
  endproperty
  a_blk_none: assert property (p_blk_none) else $error("unblocked update lost");
  property p_blk_g;
    go && blk_mode != AMEE_BLK_NONE && over_15 |=> $stable(orient_reg);
  endproperty
  a_blk_g: assert property (p_blk_g) else $error("1.5g did not block");
  property p_blk_slope;
    go && blk_mode == AMEE_BLK_SLOW && slope_02 |=> $stable(orient_reg);
  endproperty
  a_blk_slope: assert property (p_blk_slope) else $error("slope did not block");
  property p_blk_stab;
    go && blk_mode == AMEE_BLK_FULL && cand != cand_reg |=> $stable(orient_reg);
  endproperty
  a_blk_stab: assert property (p_blk_stab) else $error("unstable value passed");
  property p_zsign;
    go && mz > g02 |=> pos_status[6] == $past(smp.z[11]) || $past(blocked);
  endproperty
  a_zsign: assert property (p_zsign) else $error("z sign bit wrong");
  property p_ud;
    go && !latch && !or_ang_reg[`AMEE_UD_EN] && cand[1:0] == orient_reg[1:0]
      |=> !stat_reg[`AMEE_ST_ORI];
  endproperty
  a_ud: assert property (p_ud) else $error("z-only change raised event");
  property p_flat_hold0;
    go && !latch && flat_en && fl_chg && hcode == 2'b00 |=> stat_reg[`AMEE_ST_FLAT];
  endproperty
  a_flat_hold0: assert property (p_flat_hold0) else $error("flat event missing");
  property p_flat_pulse;
    go && !latch && !fl_fire ##1 ce && !smp.valid |-> !stat_reg[`AMEE_ST_FLAT];
  endproperty
  a_flat_pulse: assert property (p_flat_pulse) else $error("flat status stuck");
  property p_lo_clr;
    go && lo_act_reg && lo_above |=> !lo_act_reg;
  endproperty
  a_lo_clr: assert property (p_lo_clr) else $error("low-g did not reset");
  property p_hi_first;
    hi_rise |=> $onehot(first_reg) && stat_reg[`AMEE_ST_HIGH] == hi_act_reg;
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("first axis not one-hot");

  c_ori: cover property (go && ori_fire);
  c_flat: cover property (go && fl_fire && hcode != 2'b00);
  c_low: cover property (go && lo_set ##[1:20] go && lo_clr);
  c_high: cover property (hi_rise ##[1:20] go && hi_flip && hi_act_reg);

endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the motion event engines
// Assumes: 2000 us per sample, ce held high, 1024 LSB per g at 2g range
// Notes: registers reached over APB, samples pushed one valid pulse at a time
`timescale 1ns/1ns
`default_nettype none
`include "amee_consts.svh"
module tb_top
  import amee_pkg::*;
;
  logic pclk; // bus and sample clock
  logic presetn; // async reset, active low
  logic ce; // clock enable, held high
  amee_apb_req_type apb_req; // apb request to the block
  amee_apb_rsp_type apb_rsp; // apb answer
  amee_sample_type smp; // filtered sample
  logic [7:0] int_status; // event status
  logic [7:0] pos_status; // position and shock status
  int err_total; // mismatch count
  int n_tests; // comparison count
  int cyc_cnt; // cycles since start
  int k; // loop index
  int hit_at; // sample index where flat event seen
  logic [31:0] q; // read data
  logic e; // read error
  logic [7:0] ix_list [13] = '{`AMEE_IX_INTST, `AMEE_IX_POS, `AMEE_IX_ENA, `AMEE_IX_ENB,
    `AMEE_IX_LODUR, `AMEE_IX_LOTH, `AMEE_IX_HYMD, `AMEE_IX_HIDUR, `AMEE_IX_HITH,
    `AMEE_IX_ORMD, `AMEE_IX_ORANG, `AMEE_IX_FLANG, `AMEE_IX_FLHLD};
  amee_engines #(.SAMPLE_PERIOD_US(2000)) i_amee_engines (.pclk(pclk), .presetn(presetn),
    .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp), .smp(smp), .int_status(int_status),
    .pos_status(pos_status));
  // clock at 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // hang guard, far above the roughly one thousand cycles the tests need
  always @(posedge pclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      err_total++;
      final_report();
    end
  end
  // counts and verdict
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb_xfer(input logic wr_en, input logic [11:0] addr, input logic [7:0] wd,
      output logic [31:0] rq, output logic re);
    int n;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr_en, addr, {24'h0, wd}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    rq = apb_rsp.prdata;
    re = apb_rsp.pslverr;
    apb_req <= '0;
    if (n >= 50) begin
      err_total++;
    end
  endtask
  // register write by index
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    apb_xfer(1'b1, {2'b00, ix, 2'b00}, d, q, e);
  endtask
  // register read by byte address, data and error compared
  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
    apb_xfer(1'b0, addr, 8'h00, q, e);
    chk(q, exp);
    chk(e, exp_err);
  endtask
  // one sample pulse, then let status settle
  task automatic sp(input logic signed [11:0] x, input logic signed [11:0] y,
      input logic signed [11:0] z, input logic [1:0] xy);
    @(posedge pclk);
    smp <= '{1'b1, x, y, z, xy};
    @(posedge pclk);
    smp.valid <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
  // main sequence
  initial begin
    err_total = 0;
    n_tests = 0;
    cyc_cnt = 0;
    presetn = 1'b0;
    ce = 1'b1;
    apb_req = '0;
    smp = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-only status, unmapped and misaligned places
    for (k = 0; k < 13; k++) begin
      rd({2'b00, ix_list[k], 2'b00}, 32'h0, 1'b0);
    end
    wr(`AMEE_IX_INTST, 8'hFF);
    rd({2'b00, `AMEE_IX_INTST, 2'b00}, 32'h0, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    rd(12'h05A, 32'h0, 1'b1);
    wr(`AMEE_IX_HITH, 8'hA5);
    rd({2'b00, `AMEE_IX_HITH, 2'b00}, 32'hA5, 1'b0);
    // orientation events, up-down suppression, z hysteresis, blocking
    wr(`AMEE_IX_ENA, 8'h40);
    sp(0, 0, 1024, 1);
    chk(int_status[6], 1'b1);
    chk(pos_status[6:4], 3'b001);
    sp(0, 0, 1024, 1);
    chk(int_status[6], 1'b0);
    sp(0, 0, -1024, 1);
    chk(int_status[6], 1'b0);
    chk(pos_status[6], 1'b1);
    wr(`AMEE_IX_ORANG, 8'h40);
    sp(0, 0, 1024, 1);
    chk(int_status[6], 1'b1);
    sp(0, 0, -100, 1);
    chk(int_status[6], 1'b0);
    sp(0, 0, -300, 1);
    chk(int_status[6], 1'b1);
    wr(`AMEE_IX_ORMD, 8'h04);
    sp(1600, 0, -300, 2);
    chk(int_status[6], 1'b0);
    sp(0, 0, -300, 2);
    chk(int_status[6], 1'b1);
    wr(`AMEE_IX_ORMD, 8'h08);
    sp(400, 0, -300, 3);
    chk(int_status[6], 1'b0);
    sp(400, 0, -300, 3);
    chk(int_status[6], 1'b1);
    // flat detection, one-sample status, hold time, hysteresis
    wr(`AMEE_IX_ORMD, 8'h00);
    wr(`AMEE_IX_ENA, 8'h80);
    wr(`AMEE_IX_FLANG, 8'h3F);
    sp(0, 0, 1024, 0);
    chk({int_status[7], pos_status[7]}, 2'b11);
    sp(0, 0, 1024, 0);
    chk({int_status[7], pos_status[7]}, 2'b01);
    sp(1024, 0, 100, 0);
    chk(pos_status[7], 1'b0);
    wr(`AMEE_IX_FLHLD, 8'h10);
    hit_at = -1;
    for (k = 0; k < 262; k++) begin
      sp(0, 0, 1024, 0);
      if (int_status[7] === 1'b1) begin
        hit_at = k;
      end
    end
    chk(hit_at >= 254 && hit_at <= 257, 1'b1);
    wr(`AMEE_IX_FLHLD, 8'h07);
    wr(`AMEE_IX_FLANG, 8'h10);
    sp(510, 0, 1024, 0);
    chk(pos_status[7], 1'b1);
    sp(600, 0, 1024, 0);
    chk(pos_status[7], 1'b0);
    sp(510, 0, 1024, 0);
    chk(pos_status[7], 1'b0);
    // low-g single mode, delay, hysteresis reset
    wr(`AMEE_IX_ENA, 8'h00);
    wr(`AMEE_IX_ENB, 8'h08);
    wr(`AMEE_IX_LOTH, 8'h40);
    wr(`AMEE_IX_HYMD, 8'h01);
    wr(`AMEE_IX_LODUR, 8'h01);
    sp(100, 100, 100, 0);
    chk({pos_status[7], int_status[0]}, 2'b00);
    sp(100, 100, 100, 0);
    chk(int_status[0], 1'b1);
    sp(600, 0, 0, 0);
    chk(int_status[0], 1'b1);
    sp(700, 0, 0, 0);
    chk(int_status[0], 1'b0);
    // low-g sum mode
    wr(`AMEE_IX_HYMD, 8'h05);
    repeat (2) sp(200, 200, 200, 0);
    chk(int_status[0], 1'b0);
    repeat (2) sp(100, 100, 100, 0);
    chk(int_status[0], 1'b1);
    // low-g threshold fixed in g when the range doubles the lsb size
    wr(`AMEE_IX_HYMD, 8'h01);
    wr(`AMEE_IX_CTRL, 8'h01);
    sp(1000, 0, 0, 0);
    repeat (2) sp(300, 300, 300, 0);
    chk(int_status[0], 1'b0);
    repeat (2) sp(200, 200, 200, 0);
    chk(int_status[0], 1'b1);
    // high-g per-axis enable, first axis, sign, hysteresis reset
    wr(`AMEE_IX_CTRL, 8'h00);
    wr(`AMEE_IX_ENB, 8'h01);
    wr(`AMEE_IX_HITH, 8'h80);
    wr(`AMEE_IX_HYMD, 8'h40);
    wr(`AMEE_IX_HIDUR, 8'h00);
    sp(0, -1500, 0, 0);
    chk(int_status[1], 1'b0);
    sp(-1200, 0, 0, 0);
    chk({int_status[1], pos_status[3:0]}, 5'b11001);
    sp(-950, 0, 0, 0);
    chk(int_status[1], 1'b1);
    sp(-800, 0, 0, 0);
    chk({int_status[1], pos_status[3:0]}, 5'b01000);
    wr(`AMEE_IX_ENB, 8'h07);
    sp(0, 0, 1200, 0);
    chk({int_status[1], pos_status[3:0]}, 5'b10100);
    // latched mode keeps the flat event until the status clear
    wr(`AMEE_IX_ENA, 8'h80);
    wr(`AMEE_IX_CTRL, 8'h04);
    sp(1024, 0, 0, 0);
    chk(int_status[7], 1'b1);
    sp(1024, 0, 0, 0);
    chk(int_status[7], 1'b1);
    wr(`AMEE_IX_CTRL, 8'h84);
    rd({2'b00, `AMEE_IX_INTST, 2'b00}, 32'h0, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
